//--- common/sbia_pkg.sv
// constants shared by both ends of the sector buffer indirect access port
// assumes one 100 MHz clock and a synchronous active-low reset on both ends
package sbia_pkg;

  // ****************************************
  // byte register space of the access port
  // ****************************************
  localparam int SBIA_ADDR_W = 16;
  localparam logic [15:0] SBIA_OFS_DB0 = 16'hf0e0;
  localparam logic [15:0] SBIA_OFS_DB1 = 16'hf0e1;
  localparam logic [15:0] SBIA_OFS_DB2 = 16'hf0e2;
  localparam logic [15:0] SBIA_OFS_DB3 = 16'hf0e3;
  localparam logic [15:0] SBIA_OFS_ADR_LO = 16'hf0e4;
  localparam logic [15:0] SBIA_OFS_ADR_HI = 16'hf0e5;
  localparam int SBIA_WADR_W = 13;
  localparam int SBIA_LO_W = 8;
  localparam int SBIA_HI_RSV_BIT = 5;
  localparam int SBIA_HI_BUSY_BIT = 6;
  localparam int SBIA_HI_DIR_BIT = 7;
  localparam logic [7:0] SBIA_BYTE_RST = 8'h00;
  localparam logic [12:0] SBIA_WADR_RST = 13'h0000;
  localparam logic [12:0] SBIA_WADR_STEP = 13'h0001;
  localparam logic SBIA_DIR_WRITE = 1'b0;
  localparam logic SBIA_DIR_READ = 1'b1;
  localparam logic [1:0] SBIA_LANE_LAST = 2'h3;
  localparam logic [1:0] SBIA_LANE_STEP = 2'h1;

  // ****************************************
  // controller registers on the axi4-lite side
  // ****************************************
  localparam int SBIA_AXI_AW = 5;
  localparam logic [4:0] SBIA_REG_ADDR = 5'h00;
  localparam logic [4:0] SBIA_REG_WDATA = 5'h04;
  localparam logic [4:0] SBIA_REG_CMD = 5'h08;
  localparam logic [4:0] SBIA_REG_STATUS = 5'h0c;
  localparam logic [4:0] SBIA_REG_RDATA = 5'h10;
  localparam int SBIA_ADDR_DIR_BIT = 16;
  localparam int SBIA_CMD_SETADR_BIT = 0;
  localparam int SBIA_CMD_WRITE_BIT = 1;
  localparam int SBIA_CMD_READ_BIT = 2;
  localparam logic [1:0] SBIA_RESP_OKAY = 2'h0;
  localparam logic [1:0] SBIA_RESP_SLVERR = 2'h2;

  // true when the address is one of the four data byte registers
  function automatic logic sbia_is_data(input logic [15:0] a);
    return (a[15:2] == SBIA_OFS_DB0[15:2]);
  endfunction : sbia_is_data

endpackage : sbia_pkg

//--- common/sbia_if.sv
// byte-wide register port between the controller and the access port
// assumes both ends share one clock; reads answer one cycle after the strobe
`timescale 1ns/1ps
interface sbia_if;
  logic acc_wr;
  logic acc_rd;
  logic [15:0] acc_addr;
  logic [7:0] acc_wdata;
  logic [7:0] acc_rdata;

  modport device (
    input acc_wr,
    input acc_rd,
    input acc_addr,
    input acc_wdata,
    output acc_rdata
  );

  modport ctrl (
    output acc_wr,
    output acc_rd,
    output acc_addr,
    output acc_wdata,
    input acc_rdata
  );
endinterface : sbia_if

//--- verilog/sbia_dev.sv
// device end: indirect byte access to the 32-bit sector buffer
// assumes a buffer ram that answers each held request with one ack pulse
// Contract
// - program address and direction before data access
// - low byte first, high byte carries direction
// - write data bytes zero to three in order
// - byte three write stores word, sets busy
// - store done clears busy, address plus one
// - writes run on at rising addresses
// - high byte write in read direction prefetches
// - fetched word loads bytes, clears busy, increments
// - read data bytes zero to three in order
// - byte three read prefetches next word
// - reads run on at rising addresses
// - last read of each word hits byte three
// - no prefetch without a byte three read or a read-direction high byte write
// - four byte registers, read-write, reset zero
// - high register holds address twelve to eight
// - bit six is read-only busy, resets zero
// - bit seven is direction, resets zero
`timescale 1ns/1ps
module sbia_dev
  import sbia_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  sbia_if.device acc,
  output logic mem_req,
  output logic mem_we,
  output logic [12:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [3:0][7:0] db;
    logic [12:0] wadr;
    logic dir;
    logic busy;
    logic mem_req;
    logic mem_we;
    logic [12:0] mem_addr;
    logic [31:0] mem_wdata;
    logic [7:0] rdata;
  } sbia_dev_st_t;

  localparam sbia_dev_st_t SBIA_DEV_RST = '{
    db: {4{SBIA_BYTE_RST}},
    wadr: SBIA_WADR_RST,
    dir: SBIA_DIR_WRITE,
    busy: 1'b0,
    mem_req: 1'b0,
    mem_we: 1'b0,
    mem_addr: SBIA_WADR_RST,
    mem_wdata: '0,
    rdata: SBIA_BYTE_RST
  };

  sbia_dev_st_t st_ff;
  sbia_dev_st_t nxt_st;
  logic start;
  logic [1:0] lane;
  logic [7:0] hi_view;

  // ****************************************
  // register view
  // ****************************************
  assign lane = acc.acc_addr[1:0];

  always_comb
  begin
    hi_view = '0;
    hi_view[SBIA_WADR_W-SBIA_LO_W-1:0] = st_ff.wadr[SBIA_WADR_W-1:SBIA_LO_W];
    hi_view[SBIA_HI_RSV_BIT] = 1'b0;
    hi_view[SBIA_HI_BUSY_BIT] = st_ff.busy;
    hi_view[SBIA_HI_DIR_BIT] = st_ff.dir;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    nxt_st = st_ff;
    start = 1'b0;

    // buffer answer: a store or a prefetch ends here
    if (st_ff.busy && mem_ack)
    begin
      if (st_ff.dir == SBIA_DIR_READ)
      begin
        nxt_st.db = mem_rdata;
      end
      nxt_st.busy = 1'b0;
      nxt_st.mem_req = 1'b0;
      nxt_st.wadr = st_ff.wadr + SBIA_WADR_STEP;
    end

    // byte reads
    if (acc.acc_rd)
    begin
      if (sbia_is_data(acc.acc_addr))
      begin
        nxt_st.rdata = st_ff.db[lane];
        // only a byte three read releases the next prefetch
        if (lane == SBIA_LANE_LAST && st_ff.dir == SBIA_DIR_READ && !st_ff.busy)
        begin
          start = 1'b1;
        end
      end
      else if (acc.acc_addr == SBIA_OFS_ADR_LO)
      begin
        nxt_st.rdata = st_ff.wadr[SBIA_LO_W-1:0];
      end
      else if (acc.acc_addr == SBIA_OFS_ADR_HI)
      begin
        nxt_st.rdata = hi_view;
      end
      else
      begin
        nxt_st.rdata = SBIA_BYTE_RST;
      end
    end

    // byte writes
    if (acc.acc_wr)
    begin
      if (sbia_is_data(acc.acc_addr))
      begin
        nxt_st.db[lane] = acc.acc_wdata;
        if (lane == SBIA_LANE_LAST && st_ff.dir == SBIA_DIR_WRITE && !st_ff.busy)
        begin
          start = 1'b1;
        end
      end
      else if (acc.acc_addr == SBIA_OFS_ADR_LO && !st_ff.busy)
      begin
        nxt_st.wadr[SBIA_LO_W-1:0] = acc.acc_wdata;
      end
      else if (acc.acc_addr == SBIA_OFS_ADR_HI && !st_ff.busy)
      begin
        // a new address is taken only while no store or prefetch is running
        nxt_st.wadr[SBIA_WADR_W-1:SBIA_LO_W] = acc.acc_wdata[SBIA_WADR_W-SBIA_LO_W-1:0];
        nxt_st.dir = acc.acc_wdata[SBIA_HI_DIR_BIT];
        if (acc.acc_wdata[SBIA_HI_DIR_BIT] == SBIA_DIR_READ)
        begin
          start = 1'b1;
        end
      end
    end

    // launch one buffer access at the current word address
    if (start)
    begin
      nxt_st.busy = 1'b1;
      nxt_st.mem_req = 1'b1;
      nxt_st.mem_we = (nxt_st.dir == SBIA_DIR_WRITE);
      nxt_st.mem_addr = nxt_st.wadr;
      nxt_st.mem_wdata = nxt_st.db;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      st_ff <= SBIA_DEV_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign acc.acc_rdata = st_ff.rdata;
  assign mem_req = st_ff.mem_req;
  assign mem_we = st_ff.mem_we;
  assign mem_addr = st_ff.mem_addr;
  assign mem_wdata = st_ff.mem_wdata;

endmodule : sbia_dev

//--- verilog/sbia_ctrl.sv
// controller end: axi4-lite registers drive byte sequences on the access port
// assumes the port answers a byte read in the cycle after the strobe
`timescale 1ns/1ps
module sbia_ctrl
  import sbia_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [4:0] axi_awaddr,
  input wire logic axi_awvalid,
  output logic axi_awready,
  input wire logic [31:0] axi_wdata,
  input wire logic [3:0] axi_wstrb,
  input wire logic axi_wvalid,
  output logic axi_wready,
  output logic [1:0] axi_bresp,
  output logic axi_bvalid,
  input wire logic axi_bready,
  input wire logic [4:0] axi_araddr,
  input wire logic axi_arvalid,
  output logic axi_arready,
  output logic [31:0] axi_rdata,
  output logic [1:0] axi_rresp,
  output logic axi_rvalid,
  input wire logic axi_rready,
  sbia_if.ctrl acc
);

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [2:0] {
    SBIA_IDLE = 3'b000,
    SBIA_SET_HI = 3'b001,
    SBIA_POLL = 3'b010,
    SBIA_POLL_CHK = 3'b011,
    SBIA_XFER = 3'b100,
    SBIA_RD_CAP = 3'b101
  } sbia_fsm_t;

  typedef struct packed {
    logic awready, wready, aw_got, w_got, bvalid;
    logic [1:0] bresp;
    logic [4:0] awaddr;
    logic [31:0] wd;
    logic [3:0] ws;
    logic arready, rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] adr_reg, wdata_reg, rdata_reg;
    logic dev_busy, refused, op_rd;
    sbia_fsm_t fsm;
    logic [1:0] lane;
    logic acc_wr, acc_rd;
    logic [15:0] acc_addr;
    logic [7:0] acc_wdata;
  } sbia_ctrl_st_t;

  sbia_ctrl_st_t st_ff;
  sbia_ctrl_st_t nxt_st;
  logic [2:0] cmd;
  logic [31:0] cur_wdata;

  function automatic logic [31:0] sbia_strb(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : sbia_strb

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    nxt_st = st_ff;
    cmd = '0;
    cur_wdata = st_ff.wd;
    nxt_st.acc_wr = 1'b0;
    nxt_st.acc_rd = 1'b0;

    // write channel pair, taken in either order
    if (axi_awvalid && st_ff.awready)
    begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = axi_awaddr;
    end
    if (axi_wvalid && st_ff.wready)
    begin
      nxt_st.w_got = 1'b1;
      nxt_st.wd = axi_wdata;
      // strobes are kept with the data: the master may change them once w is taken
      nxt_st.ws = axi_wstrb;
    end
    if (st_ff.aw_got && st_ff.w_got)
    begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = SBIA_RESP_OKAY;
      unique case (st_ff.awaddr)
        SBIA_REG_ADDR: nxt_st.adr_reg = sbia_strb(st_ff.adr_reg, cur_wdata, st_ff.ws);
        SBIA_REG_WDATA: nxt_st.wdata_reg = sbia_strb(st_ff.wdata_reg, cur_wdata, st_ff.ws);
        SBIA_REG_CMD: cmd = cur_wdata[2:0];
        SBIA_REG_STATUS, SBIA_REG_RDATA: ;
        default: nxt_st.bresp = SBIA_RESP_SLVERR;
      endcase
    end
    if (st_ff.bvalid && axi_bready)
    begin
      nxt_st.bvalid = 1'b0;
    end
    nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
    nxt_st.wready = !nxt_st.w_got && !nxt_st.bvalid;

    // read channel
    if (axi_arvalid && st_ff.arready)
    begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = SBIA_RESP_OKAY;
      nxt_st.rdata = '0;
      unique case (axi_araddr)
        SBIA_REG_ADDR: nxt_st.rdata = st_ff.adr_reg;
        SBIA_REG_WDATA: nxt_st.rdata = st_ff.wdata_reg;
        SBIA_REG_CMD: ;
        SBIA_REG_STATUS: nxt_st.rdata = {29'h0, st_ff.refused, st_ff.dev_busy, st_ff.fsm != SBIA_IDLE};
        SBIA_REG_RDATA: nxt_st.rdata = st_ff.rdata_reg;
        default: nxt_st.rresp = SBIA_RESP_SLVERR;
      endcase
    end
    if (st_ff.rvalid && axi_rready)
    begin
      nxt_st.rvalid = 1'b0;
    end
    nxt_st.arready = !nxt_st.rvalid;

    // byte sequencer
    unique case (st_ff.fsm)
      SBIA_IDLE:
      begin
        if (cmd[SBIA_CMD_SETADR_BIT])
        begin
          nxt_st.refused = 1'b0;
          nxt_st.acc_wr = 1'b1;
          nxt_st.acc_addr = SBIA_OFS_ADR_LO;
          nxt_st.acc_wdata = st_ff.adr_reg[7:0];
          nxt_st.fsm = SBIA_SET_HI;
        end
        else if (cmd[SBIA_CMD_WRITE_BIT] || cmd[SBIA_CMD_READ_BIT])
        begin
          // word access must match the direction last programmed
          if (cmd[SBIA_CMD_READ_BIT] != st_ff.adr_reg[SBIA_ADDR_DIR_BIT])
          begin
            nxt_st.refused = 1'b1;
          end
          else
          begin
            nxt_st.refused = 1'b0;
            nxt_st.op_rd = cmd[SBIA_CMD_READ_BIT];
            nxt_st.acc_rd = 1'b1;
            nxt_st.acc_addr = SBIA_OFS_ADR_HI;
            nxt_st.fsm = SBIA_POLL;
          end
        end
      end
      SBIA_SET_HI:
      begin
        nxt_st.acc_wr = 1'b1;
        nxt_st.acc_addr = SBIA_OFS_ADR_HI;
        nxt_st.acc_wdata = {st_ff.adr_reg[SBIA_ADDR_DIR_BIT], 2'h0, st_ff.adr_reg[12:8]};
        nxt_st.fsm = SBIA_IDLE;
      end
      SBIA_POLL: nxt_st.fsm = SBIA_POLL_CHK;
      SBIA_POLL_CHK:
      begin
        nxt_st.dev_busy = acc.acc_rdata[SBIA_HI_BUSY_BIT];
        nxt_st.acc_addr = SBIA_OFS_DB0;
        nxt_st.lane = '0;
        if (acc.acc_rdata[SBIA_HI_BUSY_BIT])
        begin
          nxt_st.acc_rd = 1'b1;
          nxt_st.acc_addr = SBIA_OFS_ADR_HI;
          nxt_st.fsm = SBIA_POLL;
        end
        else
        begin
          nxt_st.acc_wr = !st_ff.op_rd;
          nxt_st.acc_rd = st_ff.op_rd;
          nxt_st.acc_wdata = st_ff.wdata_reg[7:0];
          nxt_st.fsm = SBIA_XFER;
        end
      end
      SBIA_XFER:
      begin
        if (st_ff.op_rd)
        begin
          nxt_st.fsm = SBIA_RD_CAP;
        end
        else if (st_ff.lane == SBIA_LANE_LAST)
        begin
          nxt_st.fsm = SBIA_IDLE;
        end
        else
        begin
          nxt_st.lane = st_ff.lane + SBIA_LANE_STEP;
          nxt_st.acc_wr = 1'b1;
          nxt_st.acc_addr = {st_ff.acc_addr[15:2], nxt_st.lane};
          nxt_st.acc_wdata = st_ff.wdata_reg[nxt_st.lane*8 +: 8];
        end
      end
      SBIA_RD_CAP:
      begin
        nxt_st.rdata_reg[st_ff.lane*8 +: 8] = acc.acc_rdata;
        if (st_ff.lane == SBIA_LANE_LAST)
        begin
          nxt_st.fsm = SBIA_IDLE;
        end
        else
        begin
          nxt_st.lane = st_ff.lane + SBIA_LANE_STEP;
          nxt_st.acc_rd = 1'b1;
          nxt_st.acc_addr = {st_ff.acc_addr[15:2], nxt_st.lane};
          nxt_st.fsm = SBIA_XFER;
        end
      end
      default: nxt_st.fsm = SBIA_IDLE;
    endcase
  end

  // ****************************************
  // registers and outputs
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign axi_awready = st_ff.awready;
  assign axi_wready = st_ff.wready;
  assign axi_bvalid = st_ff.bvalid;
  assign axi_bresp = st_ff.bresp;
  assign axi_arready = st_ff.arready;
  assign axi_rvalid = st_ff.rvalid;
  assign axi_rdata = st_ff.rdata;
  assign axi_rresp = st_ff.rresp;
  assign acc.acc_wr = st_ff.acc_wr;
  assign acc.acc_rd = st_ff.acc_rd;
  assign acc.acc_addr = st_ff.acc_addr;
  assign acc.acc_wdata = st_ff.acc_wdata;

endmodule : sbia_ctrl

//--- tb/sbia_props.sv
// checker for the byte port and the buffer side of the access port
// assumes one clock, synchronous active-low reset, instantiated beside the interface
`timescale 1ns/1ps
module sbia_props
  import sbia_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic acc_wr,
  input wire logic acc_rd,
  input wire logic [15:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  input wire logic [7:0] acc_rdata,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [12:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  // ****************************************
  // shadow of the port state
  // ****************************************
  logic dir_ff;
  logic [12:0] wadr_ff;
  logic [7:0] sh_ff [4];
  logic hi_wr_c;
  logic start_c;
  logic [7:0] lane_c;
  assign hi_wr_c = acc_wr && acc_addr == SBIA_OFS_ADR_HI && !mem_req;
  assign start_c = !mem_req && ((acc_wr && acc_addr == SBIA_OFS_DB3 && !dir_ff) || (hi_wr_c && acc_wdata[7])
                   || (acc_rd && acc_addr == SBIA_OFS_DB3 && dir_ff));
  assign lane_c = sh_ff[acc_addr[1:0]];
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      dir_ff <= 1'b0;
      wadr_ff <= 13'h0000;
      sh_ff <= '{default: 8'h00};
    end
    else
    begin
      if (mem_req && mem_ack && !mem_we)
        sh_ff <= '{mem_rdata[7:0], mem_rdata[15:8], mem_rdata[23:16], mem_rdata[31:24]};
      else if (acc_wr && acc_addr[15:2] == SBIA_OFS_DB0[15:2])
        sh_ff[acc_addr[1:0]] <= acc_wdata;
      if (mem_req && mem_ack)
        wadr_ff <= wadr_ff + 13'h0001;
      else if (acc_wr && !mem_req && acc_addr == SBIA_OFS_ADR_LO)
        wadr_ff[7:0] <= acc_wdata;
      else if (hi_wr_c)
        wadr_ff[12:8] <= acc_wdata[4:0];
      if (hi_wr_c)
        dir_ff <= acc_wdata[7];
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_store_start;
    acc_wr && acc_addr == SBIA_OFS_DB3 && !dir_ff && !mem_req;
  endsequence
  sequence s_req_wait;
    mem_req && !mem_ack;
  endsequence
  a_store_word_start: assert property (s_store_start |=>
    mem_req && mem_we && mem_wdata == {sh_ff[3], sh_ff[2], sh_ff[1], sh_ff[0]})
    else $error("word store not started with assembled bytes");
  a_fetch_on_high: assert property (hi_wr_c && acc_wdata[7] |=> mem_req && !mem_we)
    else $error("no prefetch after high address write");
  a_fetch_after_last: assert property (acc_rd && acc_addr == SBIA_OFS_DB3 && dir_ff && !mem_req |=>
    mem_req && !mem_we)
    else $error("no prefetch after last byte read");
  a_no_stray_req: assert property ($rose(mem_req) |-> $past(start_c))
    else $error("buffer request without a cause");
  a_req_word_addr: assert property ($rose(mem_req) |-> mem_addr == wadr_ff)
    else $error("buffer request at wrong word address");
  a_req_held: assert property (s_req_wait |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("buffer request dropped or changed before ack");
  a_req_ends: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("buffer request not closed after ack");
  a_high_readback: assert property (acc_rd && acc_addr == SBIA_OFS_ADR_HI |=>
    acc_rdata == {$past(dir_ff), $past(mem_req), 1'b0, $past(wadr_ff[12:8])})
    else $error("high register status bits wrong");
  a_lane_readback: assert property (acc_rd && acc_addr[15:2] == SBIA_OFS_DB0[15:2] && !mem_req |=>
    acc_rdata == $past(lane_c))
    else $error("data byte readback wrong");
endmodule : sbia_props

//--- tb/tb.sv
// testbench: both ends joined by the interface, buffer ram modelled here
// assumes the designer's axi register map and sequencer behaviour
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module tb;
  import sbia_pkg::*;
  logic clock, resetn, axi_awvalid, axi_awready, axi_wvalid, axi_wready, axi_bvalid, axi_bready;
  logic axi_arvalid, axi_arready, axi_rvalid, axi_rready, mem_req, mem_we;
  logic mem_ack = 1'b0;
  logic [4:0] axi_awaddr, axi_araddr;
  logic [31:0] axi_wdata, axi_rdata, mem_wdata;
  logic [31:0] mem_rdata = 32'h0;
  logic [3:0] axi_wstrb;
  logic [1:0] axi_bresp, axi_rresp, last_resp;
  logic [12:0] mem_addr;
  int miscompares, tests_run, n_store, n_fetch;
  int lat = 0;
  integer seed;
  logic [31:0] buf_mem [int];
  logic [31:0] exp_mem [int];
  sbia_if u_sbia_if ();
  sbia_ctrl u_sbia_ctrl (.clock(clock), .resetn(resetn), .axi_awaddr(axi_awaddr), .axi_awvalid(axi_awvalid),
    .axi_awready(axi_awready), .axi_wdata(axi_wdata), .axi_wstrb(axi_wstrb), .axi_wvalid(axi_wvalid),
    .axi_wready(axi_wready), .axi_bresp(axi_bresp), .axi_bvalid(axi_bvalid), .axi_bready(axi_bready),
    .axi_araddr(axi_araddr), .axi_arvalid(axi_arvalid), .axi_arready(axi_arready), .axi_rdata(axi_rdata),
    .axi_rresp(axi_rresp), .axi_rvalid(axi_rvalid), .axi_rready(axi_rready), .acc(u_sbia_if));
  sbia_dev u_sbia_dev (.clock(clock), .resetn(resetn), .acc(u_sbia_if), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  sbia_props u_sbia_props (.clock(clock), .resetn(resetn), .acc_wr(u_sbia_if.acc_wr), .acc_rd(u_sbia_if.acc_rd),
    .acc_addr(u_sbia_if.acc_addr), .acc_wdata(u_sbia_if.acc_wdata), .acc_rdata(u_sbia_if.acc_rdata),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  // ****************************************
  // buffer ram with random answer latency
  // ****************************************
  always @(posedge clock)
  begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack)
    begin
      if (lat == 0)
      begin
        mem_ack <= 1'b1;
        lat = {$random(seed)} % 4;
        if (mem_we)
        begin
          buf_mem[mem_addr] = mem_wdata;
          n_store++;
        end
        else
        begin
          mem_rdata <= buf_mem.exists(mem_addr) ? buf_mem[mem_addr] : 32'h0;
          n_fetch++;
        end
      end
      else
        lat--;
    end
  end
  // ****************************************
  // axi4-lite master and command tasks
  // ****************************************
  task automatic axi(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    logic got;
    got = 1'b0;
    q = 32'h0;
    @(posedge clock);
    if (wr)
    begin
      axi_awaddr <= a;
      axi_awvalid <= 1'b1;
      axi_wdata <= d;
      axi_wvalid <= 1'b1;
      axi_bready <= 1'b1;
    end
    else
    begin
      axi_araddr <= a;
      axi_arvalid <= 1'b1;
      axi_rready <= 1'b1;
    end
    // no timeout here: a wait that never gets an answer ends only at the watchdog
    while (!got)
    begin
      @(posedge clock);
      if (axi_awvalid && axi_awready) axi_awvalid <= 1'b0;
      if (axi_wvalid && axi_wready) axi_wvalid <= 1'b0;
      if (axi_arvalid && axi_arready) axi_arvalid <= 1'b0;
      if (wr && axi_bvalid)
      begin
        got = 1'b1;
        last_resp = axi_bresp;
        axi_bready <= 1'b0;
      end
      if (!wr && axi_rvalid)
      begin
        got = 1'b1;
        last_resp = axi_rresp;
        q = axi_rdata;
        axi_rready <= 1'b0;
      end
    end
    `CHK("axi resp", (a > SBIA_REG_RDATA) ? SBIA_RESP_SLVERR : SBIA_RESP_OKAY, last_resp)
  endtask : axi
  task automatic cmd(input logic [31:0] c);
    logic [31:0] q;
    int k;
    axi(1'b1, SBIA_REG_CMD, c, q);
    for (k = 0; k < 50; k++)
    begin
      axi(1'b0, SBIA_REG_STATUS, 32'h0, q);
      if (q[0] === 1'b0) break;
    end
    `CHK("sequencer idle", 1'b0, q[0])
  endtask : cmd
  task automatic run_words(input logic [12:0] a, input int nw);
    logic [31:0] q, w;
    int k, s0, f0;
    s0 = n_store;
    f0 = n_fetch;
    axi(1'b1, SBIA_REG_ADDR, {19'h0, a}, q);
    cmd(32'h1);
    for (k = 0; k < nw; k++)
    begin
      w = $random(seed);
      exp_mem[(a + k) % 8192] = w;
      axi(1'b1, SBIA_REG_WDATA, w, q);
      cmd(32'h2);
      // the store may still be in flight when the sequencer goes idle
      for (int t = 0; t < 8 && n_store - s0 <= k; t++)
      begin
        @(negedge clock);
      end
      `CHK("stored word", exp_mem[(a + k) % 8192], buf_mem[(a + k) % 8192])
    end
    `CHK("store count", nw, n_store - s0)
    `CHK("fetch during writes", 0, n_fetch - f0)
    axi(1'b1, SBIA_REG_ADDR, {15'h0, 1'b1, 3'h0, a}, q);
    cmd(32'h1);
    for (k = 0; k < nw; k++)
    begin
      cmd(32'h4);
      axi(1'b0, SBIA_REG_RDATA, 32'h0, q);
      `CHK("read word", exp_mem[(a + k) % 8192], q)
    end
    repeat (10) @(posedge clock);
    `CHK("fetch count", nw + 1, n_fetch - f0)
    $display("test words at %0h done", a);
  endtask : run_words
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // ****************************************
  // clock, reset, sequence, watchdog
  // ****************************************
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial
  begin
    repeat (40000) @(posedge clock);
    miscompares++;
    conclude();
  end
  initial
  begin
    logic [31:0] q;
    int s0;
    seed = 32'hd11e3a41;
    {resetn, axi_awvalid, axi_wvalid, axi_bready, axi_arvalid, axi_rready} = '0;
    {axi_awaddr, axi_araddr, axi_wdata} = '0;
    axi_wstrb = 4'hf;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    axi(1'b0, SBIA_REG_STATUS, 32'h0, q);
    `CHK("status after reset", 32'h0, q)
    run_words(13'($random(seed)), 3);
    run_words(13'h1ffe, 4);
    s0 = n_store;
    axi(1'b1, SBIA_REG_CMD, 32'h2, q);
    repeat (20) @(posedge clock);
    axi(1'b0, SBIA_REG_STATUS, 32'h0, q);
    `CHK("refused word", 1'b1, q[2])
    `CHK("refused store count", 0, n_store - s0)
    axi(1'b1, 5'h14, 32'h1, q);
    `CHK("unmapped write resp", SBIA_RESP_SLVERR, last_resp)
    axi(1'b0, 5'h14, 32'h0, q);
    `CHK("unmapped read resp", SBIA_RESP_SLVERR, last_resp)
    axi(1'b1, SBIA_REG_WDATA, 32'h0, q);
    axi_wstrb <= 4'h2;
    axi(1'b1, SBIA_REG_WDATA, 32'hffffffff, q);
    axi_wstrb <= 4'hf;
    axi(1'b0, SBIA_REG_WDATA, 32'h0, q);
    `CHK("strobed wdata", 32'h0000ff00, q)
    $display("test refusals done");
    conclude();
  end
endmodule : tb
